// ---- core/spnp_map.svh ----
// spnp_map.svh - command numbers, status bit positions, answer codes
// assumes inclusion by bare name from core design files
`ifndef SPNP_MAP_SVH
`define SPNP_MAP_SVH

// command numbers as decoded by the serial front end
`define SPNP_CMD_POLL          8'h00
`define SPNP_CMD_CLEAR         8'h01
`define SPNP_CMD_READ_IO       8'h15
`define SPNP_CMD_POLL_FULL     8'h1b
`define SPNP_CMD_PROTECT       8'h21

// status word bit positions
`define SPNP_B_ICMD_DONE       15
`define SPNP_B_NV_ERR          14
`define SPNP_B_PCMD_DONE       13
`define SPNP_B_CMD_ERR         12
`define SPNP_B_INPUT_FOUND     11
`define SPNP_B_VOLT            10
`define SPNP_B_HOLD_ERR        9
`define SPNP_B_MOVE_ERR        8
`define SPNP_B_RX_OVF          7
`define SPNP_B_CHECK_MET       6
`define SPNP_B_TOO_LONG        5
`define SPNP_B_FRAMING         4
`define SPNP_B_KILL            3
`define SPNP_B_SOFT_LIMIT      2
`define SPNP_B_RX_CKSUM        1
`define SPNP_B_ABORTED         0

// reset values and limits
`define SPNP_STATUS_RESET      16'h0000
`define SPNP_ADDR_NONE         16'h0000
`define SPNP_ADDR_ALL          16'hffff
`define SPNP_CODE_RESET        16'h0000
`define SPNP_MAX_PKT_BYTES     31
`define SPNP_NAK_BAD_CODE      8'h09
`define SPNP_NAK_BUSY          8'h01
`define SPNP_NAK_NONE          8'h00

// servo cycle of 120 us at 50 MHz
`define SPNP_SERVO_US          120
`define SPNP_CLOCK_MHZ         50
`define SPNP_SERVO_CYCLES      (`SPNP_SERVO_US * `SPNP_CLOCK_MHZ)

`endif

// ---- core/spnp_pkg.sv ----
// spnp_pkg.sv - types shared by the status poll and protect block
// assumes spnp_map.svh holds all numeric constants
`default_nettype none
package spnp_pkg;
  // answer kinds sent back to the serial framer
  typedef enum logic [2:0] {
    SPNP_ANS_ACK    = 3'h0,
    SPNP_ANS_STATUS = 3'h1,
    SPNP_ANS_IO     = 3'h3,
    SPNP_ANS_NAK    = 3'h2
  } spnp_answer_t;
endpackage
`default_nettype wire

// ---- core/spnp_core.sv ----
// spnp_core.sv - status word latching, poll answers and nv write protection
// assumes decoded commands arrive as one-cycle strobes from the serial front
// end, and that event inputs are one-cycle pulses synchronous to clock
// assumes at most one command per clock and single-pulse nv write requests
`include "spnp_map.svh"
`default_nettype none

module spnp_core #(
  parameter int unsigned SERVO_CYCLES = `SPNP_SERVO_CYCLES
) (
  // clock and reset
  input  wire logic                  clock,
  input  wire logic                  reset,
  // decoded command strobe from the serial front end
  input  wire logic                  cmd_valid,
  input  wire logic [7:0]            cmd_number,
  input  wire logic [15:0]           cmd_param0,
  input  wire logic [15:0]           cmd_param1,
  input  wire logic                  device_busy,
  // answer to the serial front end
  output logic                       ans_valid,
  output spnp_pkg::spnp_answer_t     ans_kind,
  output logic [15:0]                ans_data,
  output logic [7:0]                 ans_nak_code,
  // status events, one-cycle pulses
  input  wire logic                  ev_icmd_done,
  input  wire logic                  ev_pcmd_done,
  input  wire logic                  ev_nv_cksum_err,
  input  wire logic                  ev_cmd_err,
  input  wire logic                  ev_input_found,
  input  wire logic                  ev_volt_err,
  input  wire logic                  ev_hold_err,
  input  wire logic                  ev_move_err,
  input  wire logic                  ev_rx_overflow,
  input  wire logic                  internal_check_met,
  input  wire logic                  ev_rx_pkt_end,
  input  wire logic [7:0]            rx_pkt_bytes,
  input  wire logic                  ev_framing_err,
  input  wire logic                  ev_kill,
  input  wire logic                  ev_soft_limit,
  input  wire logic                  ev_rx_cksum_bad,
  input  wire logic                  proto_checksummed,
  input  wire logic                  ev_pkt_aborted,
  // non-volatile write gate
  input  wire logic                  nv_write_req,
  input  wire logic                  nv_write_is_save,
  input  wire logic [15:0]           nv_write_addr,
  output logic                       nv_write_grant,
  output logic                       nv_write_refused,
  output logic                       program_abort,
  // io state sources and protection view
  input  wire logic [15:0]           io_state_live,
  output logic [15:0]                first_writable_addr
);
  import spnp_pkg::*;

  // =====================================================================
  // elaboration checks
  // =====================================================================
  // a zero count never wraps, so the io snapshot would freeze after reset;
  // the counter is 32 bits, so any larger unsigned count fits it
  if (SERVO_CYCLES < 1) begin : g_bad_servo
    $error("servo cycle count must be at least one");
  end

  // =====================================================================
  // state
  // =====================================================================
  // live gathers new events, shown keeps what a poll handed out; the host
  // sees their union and clear empties shown only, so nothing unread is lost
  typedef struct packed {
    logic [15:0]  live;        // bits latched since last poll
    logic [15:0]  shown;       // bits handed to the host, cleared by clear
    logic [15:0]  lock_code;
    logic [15:0]  first_addr;
    logic [15:0]  io_word;
    logic [31:0]  servo_count;
    logic         ans_valid;
    spnp_answer_t ans_kind;
    logic [15:0]  ans_data;
    logic [7:0]   ans_nak_code;
    logic         grant;
    logic         refused;
    logic         abort;
  } spnp_state_t;

  spnp_state_t state;
  spnp_state_t next_state;

  // one-cycle event vector in status bit order
  logic [15:0] events;
  // decoded command strobes
  logic        is_poll;
  logic        is_poll_full;
  logic        is_clear;
  logic        is_protect;
  logic        is_read_io;
  // write gate terms and the union of both status halves
  logic        below_limit;
  logic        save_blocked;
  logic [15:0] merged;

  // =====================================================================
  // event vector
  // =====================================================================
  // each event lands on its own bit; a blocked save also raises 14 and 12
  always_comb begin
    events = `SPNP_STATUS_RESET;
    events[`SPNP_B_ICMD_DONE]   = ev_icmd_done;
    events[`SPNP_B_PCMD_DONE]   = ev_pcmd_done;
    events[`SPNP_B_NV_ERR]      = ev_nv_cksum_err | save_blocked;
    events[`SPNP_B_CMD_ERR]     = ev_cmd_err | save_blocked;
    events[`SPNP_B_INPUT_FOUND] = ev_input_found;
    events[`SPNP_B_VOLT]        = ev_volt_err;
    events[`SPNP_B_HOLD_ERR]    = ev_hold_err;
    events[`SPNP_B_MOVE_ERR]    = ev_move_err;
    events[`SPNP_B_RX_OVF]      = ev_rx_overflow;
    events[`SPNP_B_CHECK_MET]   = internal_check_met;
    // packet length is judged once, at the end of the packet
    events[`SPNP_B_TOO_LONG]    = ev_rx_pkt_end
                                  & (rx_pkt_bytes > 8'(`SPNP_MAX_PKT_BYTES));
    events[`SPNP_B_FRAMING]     = ev_framing_err;
    // kill is latched on every cycle it is high, so a persisting cause sets it again after clear
    events[`SPNP_B_KILL]        = ev_kill;
    events[`SPNP_B_SOFT_LIMIT]  = ev_soft_limit;
    // only protocols that carry a packet checksum can flag this bit
    events[`SPNP_B_RX_CKSUM]    = ev_rx_cksum_bad & proto_checksummed;
    events[`SPNP_B_ABORTED]     = ev_pkt_aborted;
  end

  // =====================================================================
  // command decode and write gate
  // =====================================================================
  // one strobe per command number; unknown numbers get no answer
  assign is_poll      = cmd_valid && cmd_number == `SPNP_CMD_POLL;
  assign is_poll_full = cmd_valid && cmd_number == `SPNP_CMD_POLL_FULL;
  assign is_clear     = cmd_valid && cmd_number == `SPNP_CMD_CLEAR;
  assign is_protect   = cmd_valid && cmd_number == `SPNP_CMD_PROTECT;
  assign is_read_io   = cmd_valid && cmd_number == `SPNP_CMD_READ_IO;
  // first_addr of all ones puts every user address below the limit
  assign below_limit  = state.first_addr != `SPNP_ADDR_NONE
                        && (state.first_addr == `SPNP_ADDR_ALL
                            || nv_write_addr < state.first_addr);
  assign save_blocked = nv_write_req && nv_write_is_save && below_limit;
  assign merged       = state.shown | state.live;

  // =====================================================================
  // next state
  // =====================================================================
  // everything holds by default; answer and gate pulses last one cycle
  always_comb begin
    next_state = state;
    next_state.ans_valid = 1'b0;
    next_state.grant     = 1'b0;
    next_state.refused   = 1'b0;
    next_state.abort     = 1'b0;

    // a poll moves the live bits into the shown half; later events stay
    // in live, so an intervening clear cannot lose them
    if (is_poll || is_poll_full) begin
      next_state.shown = merged;
      next_state.live  = events;
      next_state.ans_valid    = 1'b1;
      next_state.ans_nak_code = `SPNP_NAK_NONE;
      next_state.ans_data     = merged;
      // the full poll answers the word even when it is all zero
      if (is_poll && merged == `SPNP_STATUS_RESET) begin
        next_state.ans_kind = SPNP_ANS_ACK;
      end else begin
        next_state.ans_kind = SPNP_ANS_STATUS;
      end
    end else begin
      // no poll: new events simply accumulate
      next_state.live = state.live | events;
    end

    // clear only drops what has been read; events this cycle survive
    if (is_clear) begin
      next_state.shown        = `SPNP_STATUS_RESET;
      next_state.ans_valid    = 1'b1;
      next_state.ans_kind     = SPNP_ANS_ACK;
      next_state.ans_nak_code = `SPNP_NAK_NONE;
      next_state.ans_data     = `SPNP_STATUS_RESET;
    end

    // io word snapshot refreshed once per servo cycle
    if (state.servo_count >= 32'(SERVO_CYCLES - 1)) begin
      next_state.servo_count = '0;
      next_state.io_word     = io_state_live;
    end else begin
      next_state.servo_count = state.servo_count + 32'd1;
    end
    // read io answers the last snapshot, never the live pins
    if (is_read_io) begin
      next_state.ans_valid    = 1'b1;
      next_state.ans_kind     = SPNP_ANS_IO;
      next_state.ans_data     = state.io_word;
      next_state.ans_nak_code = `SPNP_NAK_NONE;
    end

    // protect command: param0 lockout code, param1 first writable address
    if (is_protect) begin
      next_state.ans_valid = 1'b1;
      next_state.ans_data  = `SPNP_STATUS_RESET;
      // a busy part keeps its settings untouched
      if (device_busy) begin
        next_state.ans_kind     = SPNP_ANS_NAK;
        next_state.ans_nak_code = `SPNP_NAK_BUSY;
      end else if (state.first_addr != `SPNP_ADDR_NONE
                   && cmd_param0 != state.lock_code) begin
        // an unprotected part has no code to check against
        next_state.ans_kind     = SPNP_ANS_NAK;
        next_state.ans_nak_code = `SPNP_NAK_BAD_CODE;
      end else begin
        // accepted: the new limit and code take effect at once
        next_state.ans_kind     = SPNP_ANS_ACK;
        next_state.ans_nak_code = `SPNP_NAK_NONE;
        next_state.first_addr   = cmd_param1;
        // an address of zero drops protection together with the code
        if (cmd_param1 == `SPNP_ADDR_NONE) begin
          next_state.lock_code = `SPNP_CODE_RESET;
        end else begin
          next_state.lock_code = cmd_param0;
        end
      end
    end

    // write gate, answered one cycle after the request
    // a plain write below the limit is refused quietly; a save also aborts
    if (nv_write_req) begin
      next_state.grant   = !below_limit;
      next_state.refused = below_limit;
      next_state.abort   = save_blocked;
    end
  end

  // =====================================================================
  // registers
  // =====================================================================
  // one register bank for the whole state
  always_ff @(posedge clock) begin
    if (reset) begin
      // every field named, so protection always comes up off
      state.live         <= `SPNP_STATUS_RESET;
      state.shown        <= `SPNP_STATUS_RESET;
      state.lock_code    <= `SPNP_CODE_RESET;
      state.first_addr   <= `SPNP_ADDR_NONE;
      state.io_word      <= '0;
      state.servo_count  <= '0;
      state.ans_valid    <= 1'b0;
      state.ans_kind     <= SPNP_ANS_ACK;
      state.ans_data     <= `SPNP_STATUS_RESET;
      state.ans_nak_code <= `SPNP_NAK_NONE;
      state.grant        <= 1'b0;
      state.refused      <= 1'b0;
      state.abort        <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  // =====================================================================
  // outputs
  // =====================================================================
  // answer outputs straight from flip-flops
  assign ans_valid           = state.ans_valid;
  assign ans_kind            = state.ans_kind;
  assign ans_data            = state.ans_data;
  assign ans_nak_code        = state.ans_nak_code;

  // write gate pulses and the current protection limit
  assign nv_write_grant      = state.grant;
  assign nv_write_refused    = state.refused;
  assign program_abort       = state.abort;
  assign first_writable_addr = state.first_addr;

endmodule
`default_nettype wire

// ---- sim/spnp_asserts.sv ----
// checker for the status poll and nv protect core ports
// assumes one clock domain with synchronous active-high reset
`default_nettype none
module spnp_asserts (
  // clock and reset
  input wire logic                   clock,
  input wire logic                   reset,
  // command and answer
  input wire logic                   cmd_valid,
  input wire logic [7:0]             cmd_number,
  input wire logic [15:0]            cmd_param1,
  input wire logic                   device_busy,
  input wire logic                   ans_valid,
  input wire spnp_pkg::spnp_answer_t ans_kind,
  input wire logic [15:0]            ans_data,
  input wire logic [7:0]             ans_nak_code,
  // nv write gate
  input wire logic                   nv_write_req,
  input wire logic                   nv_write_is_save,
  input wire logic [15:0]            nv_write_addr,
  input wire logic                   nv_write_grant,
  input wire logic                   nv_write_refused,
  input wire logic                   program_abort,
  input wire logic [15:0]            first_writable_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  import spnp_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  // ==========================================
  // blocked write: below limit, or anywhere once limit is all ones
  logic is_protect;
  logic blocked;
  assign is_protect = cmd_valid && cmd_number == 8'h21;
  assign blocked = first_writable_addr != 16'h0000 &&
    (nv_write_addr < first_writable_addr || first_writable_addr == 16'hffff);
  // ==========================================
  // answers and protection
  poll_answer_a: assert property (cmd_valid && cmd_number == 8'h00 |=> ans_valid &&
    ((ans_kind == SPNP_ANS_ACK) == (ans_data == 16'h0000))) else $error("poll answer kind wrong");
  full_poll_a: assert property (cmd_valid && cmd_number == 8'h1b |=>
    ans_valid && ans_kind == SPNP_ANS_STATUS) else $error("full poll not a status word");
  busy_nak_a: assert property (is_protect && device_busy |=>
    ans_kind == SPNP_ANS_NAK && ans_nak_code == 8'h01 && $stable(first_writable_addr))
    else $error("busy protect executed");
  protect_set_a: assert property (is_protect && !device_busy &&
    first_writable_addr == 16'h0000 |=> ans_kind == SPNP_ANS_ACK &&
    first_writable_addr == $past(cmd_param1))
    else $error("protect from unprotected did not take limit");
  hold_limit_a: assert property (!is_protect |=> $stable(first_writable_addr))
    else $error("limit moved without protect command");
  write_refuse_a: assert property (nv_write_req && blocked |=> nv_write_refused &&
    !nv_write_grant) else $error("protected write not refused");
  write_grant_a: assert property (nv_write_req && !blocked |=> nv_write_grant &&
    !nv_write_refused && !program_abort) else $error("open write not granted");
  save_abort_a: assert property (nv_write_req && nv_write_is_save && blocked |=>
    program_abort) else $error("protected save did not abort");
  // main scenarios reached
  cover property (is_protect && device_busy);
  cover property (nv_write_req && nv_write_is_save && blocked);
  cover property (cmd_valid && cmd_number == 8'h1b ##1 ans_data != 16'h0000);
endmodule
bind spnp_core spnp_asserts u_asserts (
  .clock(clock), .reset(reset), .cmd_valid(cmd_valid), .cmd_number(cmd_number),
  .cmd_param1(cmd_param1), .device_busy(device_busy), .ans_valid(ans_valid),
  .ans_kind(ans_kind), .ans_data(ans_data), .ans_nak_code(ans_nak_code),
  .nv_write_req(nv_write_req), .nv_write_is_save(nv_write_is_save),
  .nv_write_addr(nv_write_addr), .nv_write_grant(nv_write_grant),
  .nv_write_refused(nv_write_refused), .program_abort(program_abort),
  .first_writable_addr(first_writable_addr)
);
`default_nettype wire

// ---- sim/spnp_host.sv ----
// host model on the command link: issues decoded commands, keeps the answer
// assumes the answer is registered one cycle after the command edge
`default_nettype none
module spnp_host (
  // clock
  input  wire logic                   clock,
  // command strobe
  output var logic                    cmd_valid,
  output var logic [7:0]              cmd_number,
  output var logic [15:0]             cmd_param0,
  output var logic [15:0]             cmd_param1,
  // answer
  input  wire logic                   ans_valid,
  input  wire spnp_pkg::spnp_answer_t ans_kind,
  input  wire logic [15:0]            ans_data,
  input  wire logic [7:0]             ans_nak_code
);
  timeunit 1ns;
  timeprecision 1ps;
  import spnp_pkg::*;
  // last answer taken
  logic         got = 1'b0;
  spnp_answer_t kind;
  logic [15:0]  data;
  logic [7:0]   nak;
  initial cmd_valid = 1'b0;
  // one command held over its edge; idle fields scrambled so stale values never pass
  task automatic issue(input logic [7:0] n, input logic [15:0] a, input logic [15:0] b);
    @(posedge clock);
    cmd_valid  <= 1'b1;
    cmd_number <= n;
    cmd_param0 <= a;
    cmd_param1 <= b;
    @(posedge clock);
    cmd_valid  <= 1'b0;
    cmd_number <= ~n;
    cmd_param0 <= ~a;
    cmd_param1 <= ~b;
    #1;
    got  = ans_valid;
    kind = ans_kind;
    data = ans_data;
    nak  = ans_nak_code;
  endtask
endmodule
`default_nettype wire

// ---- sim/status_poll_and_nv_protect_bench.sv ----
// self-checking bench for the status poll and nv protect core
// assumes spnp_host issues commands; events and nv writes come from here
`default_nettype none
module status_poll_and_nv_protect_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import spnp_pkg::*;
  localparam int unsigned SERVO = 8;
  // ==========================================
  // stimulus and observed signals
  logic clock = 1'b0, reset = 1'b1, device_busy = 1'b0, proto = 1'b1;
  logic nv_req = 1'b0, nv_save = 1'b0, cmd_valid, ans_valid, grant, refused, abort, pr;
  logic [7:0] cmd_number, nak_code, pkt_bytes = 8'h00, b, n;
  logic [15:0] p0, p1, ans_data, fwa, m, e, ev = 16'h0000, nv_addr = 16'h0000;
  logic [15:0] io_live = 16'h0000;
  spnp_answer_t ans_kind, exp_kind;
  int error_cnt = 0, n_tests = 0, seed = 2996;
  spnp_host u_host (.clock(clock), .cmd_valid(cmd_valid), .cmd_number(cmd_number),
    .cmd_param0(p0), .cmd_param1(p1), .ans_valid(ans_valid), .ans_kind(ans_kind),
    .ans_data(ans_data), .ans_nak_code(nak_code));
  spnp_core #(.SERVO_CYCLES(SERVO)) u_dut (.clock(clock), .reset(reset),
    .cmd_valid(cmd_valid), .cmd_number(cmd_number), .cmd_param0(p0), .cmd_param1(p1),
    .device_busy(device_busy), .ans_valid(ans_valid), .ans_kind(ans_kind),
    .ans_data(ans_data), .ans_nak_code(nak_code), .ev_icmd_done(ev[15]),
    .ev_nv_cksum_err(ev[14]), .ev_pcmd_done(ev[13]), .ev_cmd_err(ev[12]),
    .ev_input_found(ev[11]), .ev_volt_err(ev[10]), .ev_hold_err(ev[9]),
    .ev_move_err(ev[8]), .ev_rx_overflow(ev[7]), .internal_check_met(ev[6]),
    .ev_rx_pkt_end(ev[5]), .rx_pkt_bytes(pkt_bytes), .ev_framing_err(ev[4]),
    .ev_kill(ev[3]), .ev_soft_limit(ev[2]), .ev_rx_cksum_bad(ev[1]),
    .proto_checksummed(proto), .ev_pkt_aborted(ev[0]), .nv_write_req(nv_req),
    .nv_write_is_save(nv_save), .nv_write_addr(nv_addr), .nv_write_grant(grant),
    .nv_write_refused(refused), .program_abort(abort), .io_state_live(io_live),
    .first_writable_addr(fwa));
  // ==========================================
  // expectation and checking
  function automatic logic [15:0] expect_word(logic [15:0] mk, logic [7:0] nb, logic cs);
    expect_word = mk;
    expect_word[5] = mk[5] && nb > 8'h1f;
    expect_word[1] = mk[1] && cs;
  endfunction
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_kind(input spnp_answer_t got, input spnp_answer_t exp);
    chk_word({13'h0000, got}, {13'h0000, exp});
  endtask
  // data compared only where the answer carries a word
  task automatic cmd(input logic [7:0] c, input logic [15:0] a, input logic [15:0] d,
                     input spnp_answer_t k, input logic [15:0] w);
    u_host.issue(c, a, d);
    chk_word({15'h0000, u_host.got}, 16'h0001);
    chk_kind(u_host.kind, k);
    if (k == SPNP_ANS_STATUS || k == SPNP_ANS_IO)
      chk_word(u_host.data, w);
  endtask
  task automatic pulse(input logic [15:0] mk, input logic [7:0] nb, input logic cs);
    @(posedge clock);
    ev <= mk;
    pkt_bytes <= nb;
    proto <= cs;
    @(posedge clock);
    ev <= 16'h0000;
  endtask
  task automatic nv(input logic s, input logic [15:0] a, input logic ok);
    @(posedge clock);
    nv_req <= 1'b1;
    nv_save <= s;
    nv_addr <= a;
    @(posedge clock);
    nv_req <= 1'b0;
    nv_addr <= ~a;
    #1;
    chk_word({13'h0000, grant, refused, abort}, {13'h0000, ok, !ok, !ok && s});
  endtask
  task automatic complete_run();
    $display("errors %0d of %0d checks", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // ==========================================
  // clock, watchdog, sequence
  initial forever #10 clock = ~clock;
  // generous bound: the sequence needs well under a thousand cycles
  initial begin
    #400000;
    error_cnt++;
    complete_run();
  end
  initial begin
    repeat (5) @(posedge clock);
    reset <= 1'b0;
    cmd(8'h00, 16'h0000, 16'h0000, SPNP_ANS_ACK, 16'h0000);
    cmd(8'h1b, 16'h0000, 16'h0000, SPNP_ANS_STATUS, 16'h0000);
    // single bits first, then random bursts with packet length 31 on odd passes, random on even
    for (int i = 0; i < 40; i++) begin
      m = (i < 16) ? 16'h0001 << i : 16'($random(seed));
      b = (i < 16) ? 8'h20 : (i[0] ? 8'h1f : 8'($random(seed)));
      pr = (i < 16) || i[1];
      e = expect_word(m, b, pr);
      n = i[0] ? 8'h00 : 8'h1b;
      exp_kind = (n == 8'h00 && e == 16'h0000) ? SPNP_ANS_ACK : SPNP_ANS_STATUS;
      pulse(m, b, pr);
      cmd(n, 16'h0000, 16'h0000, exp_kind, e);
      cmd(8'h01, 16'h0000, 16'h0000, SPNP_ANS_ACK, 16'h0000);
      cmd(8'h00, 16'h0000, 16'h0000, SPNP_ANS_ACK, 16'h0000);
    end
    pulse(16'h8000, 8'h00, 1'b1);
    cmd(8'h00, 16'h0000, 16'h0000, SPNP_ANS_STATUS, 16'h8000);
    pulse(16'h0400, 8'h00, 1'b1);
    cmd(8'h01, 16'h0000, 16'h0000, SPNP_ANS_ACK, 16'h0000);
    cmd(8'h1b, 16'h0000, 16'h0000, SPNP_ANS_STATUS, 16'h0400);
    @(posedge clock);
    device_busy <= 1'b1;
    cmd(8'h21, 16'h04d2, 16'h03e8, SPNP_ANS_NAK, 16'h0000);
    chk_word({8'h00, u_host.nak}, 16'h0001);
    chk_word(fwa, 16'h0000);
    @(posedge clock);
    device_busy <= 1'b0;
    cmd(8'h21, 16'h04d2, 16'h03e8, SPNP_ANS_ACK, 16'h0000);
    chk_word(fwa, 16'h03e8);
    cmd(8'h00, 16'h0000, 16'h0000, SPNP_ANS_STATUS, 16'h0400);
    cmd(8'h01, 16'h0000, 16'h0000, SPNP_ANS_ACK, 16'h0000);
    nv(1'b1, 16'h03e7, 1'b0);
    cmd(8'h1b, 16'h0000, 16'h0000, SPNP_ANS_STATUS, 16'h5000);
    nv(1'b1, 16'h03e8, 1'b1);
    cmd(8'h21, 16'h0007, 16'hffff, SPNP_ANS_NAK, 16'h0000);
    chk_word({8'h00, u_host.nak}, 16'h0009);
    cmd(8'h21, 16'h04d2, 16'hffff, SPNP_ANS_ACK, 16'h0000);
    nv(1'b0, 16'hffff, 1'b0);
    cmd(8'h21, 16'h04d2, 16'h0000, SPNP_ANS_ACK, 16'h0000);
    cmd(8'h21, 16'h0063, 16'h0100, SPNP_ANS_ACK, 16'h0000);
    cmd(8'h21, 16'h04d2, 16'h0000, SPNP_ANS_NAK, 16'h0000);
    chk_word({8'h00, u_host.nak}, 16'h0009);
    for (int i = 0; i < 8; i++) begin
      m = 16'($random(seed)) >> (i * 2);
      nv(i[0], m, m >= 16'h0100);
    end
    // io word is sampled once per servo cycle, so wait past one wrap
    for (int i = 0; i < 2; i++) begin
      @(posedge clock);
      io_live <= 16'($random(seed));
      repeat (SERVO + 2) @(posedge clock);
      cmd(8'h15, 16'h0000, 16'h0000, SPNP_ANS_IO, io_live);
    end
    complete_run();
  end
endmodule
`default_nettype wire
